// ===== tb/arcr_host.sv
// Purpose: host processor model driving byte accesses on the register port
// Assumes: serial link already decoded into one-cycle read and write strobes
// Notes:   requests change just after a rising edge and are held until taken
`default_nettype none
module arcr_host (
   // clock
   input  wire logic       ref_clk,
   // register port
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 8'h00;
   end
   // one write strobe; data inverted after release so stale data is never mistaken
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~v;
   endtask
   // one read strobe, answer taken at the edge where valid shows
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      int n;
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      v = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask
   // pll setup; caller keeps P, J and D inside the legal window
   task automatic pll_prog(input logic [3:0] p, input logic [5:0] j, input logic [13:0] d);
      wr_reg(8'h0F, {p, j[5:2]});
      wr_reg(8'h10, {j[1:0], d[13:8]});
      wr_reg(8'h11, d[7:0]);
   endtask
endmodule
`default_nettype wire

// ===== tb/arcr_regs_bench.sv
// Purpose: self-checking bench for the receiver control register group
// Assumes: host model drives the register port, bench drives pins and lock status
// Notes:   recovery clock runs at 1/8 of ref_clk so the synchronizer sees every edge
`default_nettype none
module arcr_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    ref_clk = 1'b0;
   logic                    rst = 1'b1;
   wire logic [7:0]         reg_addr, reg_wdata, reg_rdata;
   wire logic               reg_wr, reg_rd, reg_rvalid;
   logic [3:0]              line_rx_in = 4'h0;
   logic                    dec_unl = 1'b0, pll_unl = 1'b0;
   arcr_pkg::arcr_detect_t  detect_in = '0;
   logic [23:0]             audio_in = 24'h000000;
   logic [2:0]              pc = 3'h0;
   wire logic               bit_out, refsel, bxe, cfg_ok, rco, oe_n;
   wire logic [23:0]        audio_out;
   arcr_pkg::arcr_pll_cfg_t cfg;
   int                      n_fail = 0, check_count = 0, rises, e, seed;
   logic [7:0]              d, v;
   logic [7:0]              mdl [0:6];
   ////////////////////////////////////////////////////////////////////////////////////////////
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) pc <= pc + 3'h1;
   always @(posedge rco) rises++;
   arcr_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   arcr_regs uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .line_rx_in(line_rx_in), .decoder_bit_out(bit_out), .ref_clock_select(refsel),
      .buffer_xfer_enable(bxe), .reference_pll_cfg(cfg), .reference_pll_cfg_ok(cfg_ok),
      .decoder_unlock(dec_unl), .recovery_pll_unlock(pll_unl), .detect_in(detect_in),
      .audio_in(audio_in), .audio_out(audio_out), .recovery_pll_clk(pc[2]),
      .recovered_clk_out(rco), .recovered_clk_out_oe_n(oe_n));
   ////////////////////////////////////////////////////////////////////////////////////////////
   // compare and count; case inequality so unknowns never match known values
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // writable bits of each register in the model
   function automatic logic [7:0] wmask(input int a);
      return (a == 13) ? 8'h1B : (a == 14) ? 8'h1F : (a < 18) ? 8'hFF : 8'h00;
   endfunction
   // watchdog well beyond the expected run of a few thousand cycles
   initial begin
      #100000;
      n_fail++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = $urandom(82430);
      foreach (mdl[i]) mdl[i] = 8'h00;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 13; a < 20; a++) begin
         host.rd_reg(8'(a), d);
         chk(d, 0);
      end
      chk(oe_n, 1);
      chk(bxe, 1);
      // random writes to every mapped register, status and one unmapped address included
      repeat (4) begin
         detect_in <= arcr_pkg::arcr_detect_t'(4'($urandom));
         for (int a = 13; a < 21; a++) begin
            v = 8'($urandom);
            host.wr_reg(8'(a), v);
            if (a < 20) mdl[a-13] = v & wmask(a);
         end
         mdl[5] = {6'h00, detect_in[2], detect_in[3]};
         mdl[6] = {6'h00, detect_in[1:0]};
         for (int a = 13; a < 21; a++) begin
            host.rd_reg(8'(a), d);
            chk(d, (a < 20) ? mdl[a-13] : 8'h00);
         end
         chk(refsel, mdl[0][3]);
         chk(bxe, !mdl[0][4]);
         chk(oe_n, !mdl[1][0]);
         chk(cfg, {mdl[2], mdl[3], mdl[4]});
         chk(cfg_ok, {mdl[2][3:0], mdl[3][7:6]} != 0 && {mdl[3][5:0], mdl[4]} <= 9999);
      end
      host.pll_prog(4'h2, 6'h07, 14'h0B02);
      #1;
      chk(cfg, 24'h21CB02);
      chk(cfg_ok, 1);
      // host freezes the buffer copy to read it, then lets it resume
      host.wr_reg(8'h0D, 8'h10);
      #1;
      chk(bxe, 0);
      host.wr_reg(8'h0D, 8'h00);
      #1;
      chk(bxe, 1);
      // rate code read back before the divider is chosen
      host.rd_reg(8'h13, d);
      chk(d, mdl[6]);
      // each input route with changing line levels
      for (int s = 0; s < 4; s++) begin
         host.wr_reg(8'h0D, 8'(s));
         repeat (4) begin
            @(posedge ref_clk) line_rx_in <= 4'($urandom);
            repeat (5) @(posedge ref_clk);
            chk(bit_out, line_rx_in[s]);
         end
      end
      // mute only with auto-mute on and both unlock flags
      for (int m = 0; m < 8; m++) begin
         host.wr_reg(8'h0E, {4'h0, m[2], 3'h0});
         @(posedge ref_clk);
         dec_unl  <= m[0];
         pll_unl  <= m[1];
         audio_in <= 24'($urandom);
         repeat (4) @(posedge ref_clk);
         chk(audio_out, (m == 7) ? 24'h000000 : audio_in);
      end
      // divider codes, then unlock with clock stop and free-run
      for (int c = 0; c < 6; c++) begin
         host.wr_reg(8'h0E, {3'h0, c == 5, 1'b0, (c < 4) ? 2'(c) : 2'h1, 1'b1});
         @(posedge ref_clk);
         dec_unl <= c > 3;
         pll_unl <= c > 3;
         repeat (16) @(posedge ref_clk);
         rises = 0;
         repeat (256) @(posedge ref_clk);
         e = (c == 4) ? 0 : (c < 4) ? (32 >> c) : 16;
         chk(rises + 1 >= e && rises <= e + 1, 1);
         chk(oe_n, 0);
      end
      results();
   end
endmodule
`default_nettype wire

// ===== verilog/arcr_pkg.sv
// Purpose: shared constants and carrier types for the receiver control register group
// Assumes: 8-bit registers reached by byte address through the host register port
// Notes:   all reset values are zero, which is the default of every field
`default_nettype none
package arcr_pkg;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [7:0] ADDR_RX_CTRL_ONE   = 8'h0D;
   localparam logic [7:0] ADDR_RX_CTRL_TWO   = 8'h0E;
   localparam logic [7:0] ADDR_REF_PLL_ONE   = 8'h0F;
   localparam logic [7:0] ADDR_REF_PLL_TWO   = 8'h10;
   localparam logic [7:0] ADDR_REF_PLL_THREE = 8'h11;
   localparam logic [7:0] ADDR_DETECT_STAT   = 8'h12;
   localparam logic [7:0] ADDR_RX_STAT_ONE   = 8'h13;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTL1_MUX_LSB    = 0;
   localparam int CTL1_REFSEL_BIT = 3;
   localparam int CTL1_BTD_BIT    = 4;
   localparam int CTL2_OE_BIT     = 0;
   localparam int CTL2_DIV_LSB    = 1;
   localparam int CTL2_AMUTE_BIT  = 3;
   localparam int CTL2_LOL_BIT    = 4;
   localparam int REFERENCE_PLL_P_LSB      = 4;
   localparam int REFERENCE_PLL_JHI_LSB    = 0;
   localparam int RECOVERY_PLL_JLO_LSB    = 6;
   localparam int RECOVERY_PLL_DHI_LSB    = 0;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // reset values and limits
   localparam logic [7:0]  RST_CTRL      = 8'h00;
   localparam logic [5:0]  J_MIN         = 6'h01;
   localparam logic [13:0] D_MAX         = 14'h270F;
   localparam int          PLL_TARGET_KHZ = 98304;
   localparam int          AUDIO_W       = 24;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // recovered clock divider and rate codes
   typedef enum logic [1:0] {
      ARCR_DIV_1 = 2'b00,
      ARCR_DIV_2 = 2'b01,
      ARCR_DIV_4 = 2'b10,
      ARCR_DIV_8 = 2'b11
   } arcr_div_t;
   typedef enum logic [1:0] {
      ARCR_RATE_NONE = 2'b00,
      ARCR_RATE_128  = 2'b01,
      ARCR_RATE_256  = 2'b10,
      ARCR_RATE_512  = 2'b11
   } arcr_rate_t;
   ////////////////////////////////////////////////////////////////////////////////////////////
   // reference pll programming carried to the analog macro
   typedef struct packed {
      logic [3:0]  pre_div;
      logic [5:0]  mult_int;
      logic [13:0] mult_frac;
   } arcr_pll_cfg_t;
   // detector results from the decoder core
   typedef struct packed {
      logic       compressed_burst_flag;
      logic       disc_surround_flag;
      arcr_rate_t max_recovered_rate;
   } arcr_detect_t;
   // whole state of the block
   typedef struct packed {
      logic [1:0]         recv_input_select;
      logic               ref_clock_select;
      logic               buffer_xfer_disable;
      logic               recovered_clk_out_en;
      arcr_div_t          recovered_clk_divider;
      logic               auto_mute_on_unlock;
      logic               unlock_clock_mode;
      arcr_pll_cfg_t      pll;
      logic [3:0]         line_s1;
      logic [3:0]         line_s2;
      logic               ck_s1;
      logic               ck_s2;
      logic               ck_s3;
      logic [1:0]         div_cnt;
      logic               rclk;
      logic               dec_bit;
      logic [AUDIO_W-1:0] audio;
      arcr_detect_t       det;
      logic [7:0]         rdata;
      logic               rvalid;
   } arcr_state_t;
endpackage
`default_nettype wire

// ===== verilog/arcr_regs.sv
// Purpose: receiver control and status registers with the logic they steer
// Assumes: host interface decodes the serial link and presents byte accesses here
// Notes:   recovery pll clock is sampled on ref_clk, so its rate must stay well below 125 MHz
//
// What this block does
// - route one of four line inputs
// - reference pll fed from pin or master clock
// - buffer transfers stop while disable bit set
// - recovered clock pin floats until enabled
// - divide recovery pll clock by 1,2,4,8
// - auto-mute forces audio low on unlock
// - unlock stops or free-runs recovered clock
// - pll clock is reference times K over P
// - K is J 1..63 plus D 0..9999
// - pll settings packed across three registers
// - read-only flag for compressed burst stream
// - read-only flag for disc surround stream
// - report maximum recovered clock rate code
`default_nettype none
module arcr_regs (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   // host register port
   input  wire logic [7:0]                   reg_addr,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [7:0]                   reg_wdata,
   output logic      [7:0]                   reg_rdata,
   output logic                              reg_rvalid,
   // line receiver pins and decoder side
   input  wire logic [3:0]                   line_rx_in,
   output logic                              decoder_bit_out,
   output logic                              ref_clock_select,
   output logic                              buffer_xfer_enable,
   output arcr_pkg::arcr_pll_cfg_t           reference_pll_cfg,
   output logic                              reference_pll_cfg_ok,
   // lock status and detectors
   input  wire logic                         decoder_unlock,
   input  wire logic                         recovery_pll_unlock,
   input  wire arcr_pkg::arcr_detect_t       detect_in,
   // audio path
   input  wire logic [arcr_pkg::AUDIO_W-1:0] audio_in,
   output logic      [arcr_pkg::AUDIO_W-1:0] audio_out,
   // recovery pll clock and recovered clock pin
   input  wire logic                         recovery_pll_clk,
   output logic                              recovered_clk_out,
   output logic                              recovered_clk_out_oe_n
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // audio width must hold at least one sample bit
   if (arcr_pkg::AUDIO_W < 1) begin : g_bad_width
      $error("audio width must be positive");
   end

   arcr_pkg::arcr_state_t st_ff;
   arcr_pkg::arcr_state_t nxt_st;
   logic                  unlocked;
   logic                  ck_rise;
   logic [1:0]            div_last;
   logic                  sel_bit;

   // both detectors must agree before unlock takes effect
   assign unlocked = decoder_unlock & recovery_pll_unlock;
   assign ck_rise  = st_ff.ck_s2 & ~st_ff.ck_s3;
   assign sel_bit  = st_ff.line_s2[st_ff.recv_input_select];

   // divider terminal count per selected ratio
   always_comb begin
      case (st_ff.recovered_clk_divider)
         arcr_pkg::ARCR_DIV_4: div_last = 2'h1;
         arcr_pkg::ARCR_DIV_8: div_last = 2'h3;
         default:              div_last = 2'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.rvalid = 1'b0;
      // pins pass two flops; the first stage feeds only the second
      nxt_st.line_s1 = line_rx_in;
      nxt_st.line_s2 = st_ff.line_s1;
      nxt_st.ck_s1   = recovery_pll_clk;
      nxt_st.ck_s2   = st_ff.ck_s1;
      nxt_st.ck_s3   = st_ff.ck_s2;
      nxt_st.dec_bit = sel_bit;
      nxt_st.det     = detect_in;
      // auto-mute only on combined loss of lock
      if (st_ff.auto_mute_on_unlock && unlocked) begin
         nxt_st.audio = '0;
      end else begin
         nxt_st.audio = audio_in;
      end
      // recovered clock divider; stop mode parks the clock low
      if (unlocked && !st_ff.unlock_clock_mode) begin
         nxt_st.rclk    = 1'b0;
         nxt_st.div_cnt = 2'h0;
      end else if (st_ff.recovered_clk_divider == arcr_pkg::ARCR_DIV_1) begin
         nxt_st.rclk    = st_ff.ck_s2;
         nxt_st.div_cnt = 2'h0;
      end else if (ck_rise) begin
         if (st_ff.div_cnt >= div_last) begin
            nxt_st.rclk    = ~st_ff.rclk;
            nxt_st.div_cnt = 2'h0;
         end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
         end
      end
      // host writes; status addresses have no storage to write
      if (reg_wr) begin
         case (reg_addr)
            arcr_pkg::ADDR_RX_CTRL_ONE: begin
               nxt_st.recv_input_select   = reg_wdata[arcr_pkg::CTL1_MUX_LSB +: 2];
               nxt_st.ref_clock_select    = reg_wdata[arcr_pkg::CTL1_REFSEL_BIT];
               nxt_st.buffer_xfer_disable = reg_wdata[arcr_pkg::CTL1_BTD_BIT];
            end
            arcr_pkg::ADDR_RX_CTRL_TWO: begin
               nxt_st.recovered_clk_out_en  = reg_wdata[arcr_pkg::CTL2_OE_BIT];
               nxt_st.recovered_clk_divider =
                  arcr_pkg::arcr_div_t'(reg_wdata[arcr_pkg::CTL2_DIV_LSB +: 2]);
               nxt_st.auto_mute_on_unlock   = reg_wdata[arcr_pkg::CTL2_AMUTE_BIT];
               nxt_st.unlock_clock_mode     = reg_wdata[arcr_pkg::CTL2_LOL_BIT];
            end
            arcr_pkg::ADDR_REF_PLL_ONE: begin
               nxt_st.pll.pre_div       = reg_wdata[arcr_pkg::REFERENCE_PLL_P_LSB +: 4];
               nxt_st.pll.mult_int[5:2] = reg_wdata[arcr_pkg::REFERENCE_PLL_JHI_LSB +: 4];
            end
            arcr_pkg::ADDR_REF_PLL_TWO: begin
               nxt_st.pll.mult_int[1:0]   = reg_wdata[arcr_pkg::RECOVERY_PLL_JLO_LSB +: 2];
               nxt_st.pll.mult_frac[13:8] = reg_wdata[arcr_pkg::RECOVERY_PLL_DHI_LSB +: 6];
            end
            arcr_pkg::ADDR_REF_PLL_THREE: begin
               nxt_st.pll.mult_frac[7:0] = reg_wdata;
            end
            default: begin
               nxt_st.rdata = st_ff.rdata;
            end
         endcase
      end
      // host reads; unmapped and unused bits return zero
      if (reg_rd) begin
         nxt_st.rvalid = 1'b1;
         case (reg_addr)
            arcr_pkg::ADDR_RX_CTRL_ONE: nxt_st.rdata = {3'h0, st_ff.buffer_xfer_disable,
               st_ff.ref_clock_select, 1'b0, st_ff.recv_input_select};
            arcr_pkg::ADDR_RX_CTRL_TWO: nxt_st.rdata = {3'h0, st_ff.unlock_clock_mode,
               st_ff.auto_mute_on_unlock, st_ff.recovered_clk_divider,
               st_ff.recovered_clk_out_en};
            arcr_pkg::ADDR_REF_PLL_ONE:
               nxt_st.rdata = {st_ff.pll.pre_div, st_ff.pll.mult_int[5:2]};
            arcr_pkg::ADDR_REF_PLL_TWO:
               nxt_st.rdata = {st_ff.pll.mult_int[1:0], st_ff.pll.mult_frac[13:8]};
            arcr_pkg::ADDR_REF_PLL_THREE:
               nxt_st.rdata = st_ff.pll.mult_frac[7:0];
            arcr_pkg::ADDR_DETECT_STAT: nxt_st.rdata = {6'h00,
               st_ff.det.disc_surround_flag, st_ff.det.compressed_burst_flag};
            arcr_pkg::ADDR_RX_STAT_ONE:
               nxt_st.rdata = {6'h00, st_ff.det.max_recovered_rate};
            default: nxt_st.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state register; every field resets to zero, the documented default
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata              = st_ff.rdata;
   assign reg_rvalid             = st_ff.rvalid;
   assign decoder_bit_out        = st_ff.dec_bit;
   assign ref_clock_select       = st_ff.ref_clock_select;
   assign buffer_xfer_enable     = ~st_ff.buffer_xfer_disable;
   assign reference_pll_cfg      = st_ff.pll;
   // analog pll accepts only J 1..63 and D up to 9999
   assign reference_pll_cfg_ok   = (st_ff.pll.mult_int >= arcr_pkg::J_MIN) &&
                                   (st_ff.pll.mult_frac <= arcr_pkg::D_MAX);
   assign audio_out              = st_ff.audio;
   assign recovered_clk_out      = st_ff.rclk;
   // enable is active low: pin floats until software turns it on
   assign recovered_clk_out_oe_n = ~st_ff.recovered_clk_out_en;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // checks
   chk_mux_route: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> decoder_bit_out == $past(sel_bit))
      else $error("selected line input not routed");
   chk_refsel_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_ONE
      |=> ref_clock_select == $past(reg_wdata[3]))
      else $error("reference clock select not taken");
   chk_xfer_stop: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_ONE
      |=> buffer_xfer_enable == !$past(reg_wdata[4]))
      else $error("buffer transfer enable wrong");
   chk_pin_float: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_TWO && !reg_wdata[0]
      |=> recovered_clk_out_oe_n)
      else $error("recovered clock pin driven while disabled");
   chk_div_two: assert property (@(posedge ref_clk) disable iff (rst)
      st_ff.recovered_clk_divider == arcr_pkg::ARCR_DIV_2 && ck_rise && !unlocked
      && !reg_wr |=> recovered_clk_out != $past(recovered_clk_out))
      else $error("divide by two missed a toggle");
   chk_auto_mute: assert property (@(posedge ref_clk) disable iff (rst)
      st_ff.auto_mute_on_unlock && decoder_unlock && recovery_pll_unlock
      |=> audio_out == '0)
      else $error("audio not muted on unlock");
   chk_unlock_stop: assert property (@(posedge ref_clk) disable iff (rst)
      !st_ff.unlock_clock_mode && unlocked |=> !recovered_clk_out ##0 st_ff.div_cnt == 2'h0)
      else $error("recovered clock kept running on unlock");
   chk_cfg_range: assert property (@(posedge ref_clk) disable iff (rst)
      reference_pll_cfg.mult_int == 6'h00 |-> !reference_pll_cfg_ok)
      else $error("zero integer multiplier flagged legal");
   chk_pll_fields: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_REF_PLL_TWO
      |=> reference_pll_cfg.mult_int[1:0] == $past(reg_wdata[7:6])
          && reference_pll_cfg.mult_frac[13:8] == $past(reg_wdata[5:0]))
      else $error("pll register two fields misplaced");
   // status is captured a cycle before the read, so the answer is two samples old
   chk_detect_read: assert property (@(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == arcr_pkg::ADDR_DETECT_STAT
      |=> reg_rdata == {6'h00, $past(detect_in.disc_surround_flag, 2),
          $past(detect_in.compressed_burst_flag, 2)})
      else $error("detection flags read back wrong");
   chk_rate_read: assert property (@(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == arcr_pkg::ADDR_RX_STAT_ONE
      |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
      else $error("rate status upper bits not zero");
   chk_ro_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_STAT_ONE |=> $stable(st_ff.recv_input_select)
      && $stable(st_ff.pll))
      else $error("status write disturbed control state");

   ////////////////////////////////////////////////////////////////////////////////////////////
   // control fields land where the host put them
   chk_mux_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_ONE
      |=> st_ff.recv_input_select == $past(reg_wdata[1:0]))
      else $error("input select not taken");

   chk_pin_drive: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_TWO && reg_wdata[0]
      |=> !recovered_clk_out_oe_n)
      else $error("recovered clock pin not driven when enabled");

   chk_div_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_TWO
      |=> st_ff.recovered_clk_divider == $past(reg_wdata[2:1]))
      else $error("divider code not taken");

   chk_amute_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_TWO
      |=> st_ff.auto_mute_on_unlock == $past(reg_wdata[3]))
      else $error("auto-mute bit not taken");

   chk_lol_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_RX_CTRL_TWO
      |=> st_ff.unlock_clock_mode == $past(reg_wdata[4]))
      else $error("unlock clock mode not taken");

   // audio must pass untouched whenever mute is not called for
   chk_audio_pass: assert property (@(posedge ref_clk) disable iff (rst)
      !(st_ff.auto_mute_on_unlock && unlocked)
      |=> audio_out == $past(audio_in))
      else $error("audio altered without mute");

   // free-run mode keeps the clock going through unlock
   chk_free_run: assert property (@(posedge ref_clk) disable iff (rst)
      st_ff.unlock_clock_mode && st_ff.recovered_clk_divider == arcr_pkg::ARCR_DIV_1
      |=> recovered_clk_out == $past(st_ff.ck_s2))
      else $error("free-run clock did not follow pll");

   chk_div_hold: assert property (@(posedge ref_clk) disable iff (rst)
      st_ff.recovered_clk_divider == arcr_pkg::ARCR_DIV_2 && !ck_rise && !unlocked
      |=> $stable(recovered_clk_out))
      else $error("divided clock moved without a pll edge");

   // pll bytes
   chk_pll_one: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_REF_PLL_ONE
      |=> reference_pll_cfg.pre_div == $past(reg_wdata[7:4])
          && reference_pll_cfg.mult_int[5:2] == $past(reg_wdata[3:0]))
      else $error("pll register one fields misplaced");

   chk_pll_three: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == arcr_pkg::ADDR_REF_PLL_THREE
      |=> reference_pll_cfg.mult_frac[7:0] == $past(reg_wdata))
      else $error("pll register three not taken");

   chk_frac_range: assert property (@(posedge ref_clk) disable iff (rst)
      reference_pll_cfg.mult_frac > 14'h270F |-> !reference_pll_cfg_ok)
      else $error("oversized fraction flagged legal");

   chk_cfg_legal: assert property (@(posedge ref_clk) disable iff (rst)
      reference_pll_cfg.mult_int != 6'h00 && reference_pll_cfg.mult_frac <= 14'h270F
      |-> reference_pll_cfg_ok)
      else $error("legal multiplier flagged bad");

   // status and read port
   chk_rate_value: assert property (@(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr == arcr_pkg::ADDR_RX_STAT_ONE
      |=> reg_rdata[1:0] == $past(detect_in.max_recovered_rate, 2))
      else $error("rate code read back wrong");

   chk_read_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after read");

   chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (rst)
      reg_rd && reg_addr > arcr_pkg::ADDR_RX_STAT_ONE |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   // reset leaves the pin floating and the port quiet
   chk_reset_state: assert property (@(posedge ref_clk)
      rst |=> !reg_rvalid && recovered_clk_out_oe_n && audio_out == '0)
      else $error("reset state wrong");
endmodule
`default_nettype wire
